// >>> rtl/cgswu_top.sv
// Clock gear, prescaler select, standby mode control and warm-up counter
`default_nettype none
module cgswu_top
    import cgswu_pkg::*;
#(
    parameter int WU_W = 12
) (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic        clk_en_in,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output var  logic [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Core and wake sources
    input  wire logic        wfi_in,
    input  wire logic        irq_wake_in,
    input  wire logic        watchdog_nmi_request_in,
    input  wire logic [3:0]  idle_run_en_in,
    input  wire logic        osc_tick_in,
    // Clock enables and pin control
    output var  logic [4:0]  gear_div_out,
    output var  logic [4:0]  prescale_div_out,
    output var  logic        periph_source_sel_out,
    output var  logic        pll_x8_en_out,
    output logic             core_clk_en_out,
    output logic [3:0]       idle_periph_clk_en_out,
    output logic             fixed_periph_clk_en_out,
    output logic             analog_clk_en_out,
    output logic             osc_run_out,
    output logic             pin_io_en_out,
    output logic             osc_pin_high_out,
    output var  logic [1:0]  mode_out
);
    // =====================================================
    // Registers and next values
    cgswu_mode_t       mode_r, mode_nxt;
    logic [2:0]        gear_r, gear_nxt, gear_req_r, gear_req_nxt;
    logic [2:0]        gear_dly_r, gear_dly_nxt;
    logic [2:0]        prsc_r, prsc_nxt;
    logic              psrc_r, psrc_nxt;
    logic              pll_on_r, pll_on_nxt;
    logic              sela_r, sela_nxt, selb_r, selb_nxt;
    logic [WU_W-1:0]   wucnt_r, wucnt_nxt;
    logic              busy_r, busy_nxt;
    logic [WU_W+3:0]   wu_ctr_r, wu_ctr_nxt;
    logic [2:0]        stby_r, stby_nxt;
    logic              drive_r, drive_nxt;
    logic              stop_wake_en_r, stop_wake_en_nxt;
    logic [31:0]       rdata_nxt;

    logic wr_sys, wr_osc, wr_stby, wr_stat, rd_go, rd_pend_r, rd_pend_nxt;

    function automatic logic [4:0] div_of(input logic [2:0] sel);
        logic [4:0] d;
        d = 5'h01;
        if (sel <= 3'h4) begin
            d = 5'h01 << sel;
        end
        return d;
    endfunction

    // =====================================================
    // Bus decode: reads wait one cycle so data stands from a flop
    assign avs_waitrequest_out = avs_read_in && !rd_pend_r;
    assign wr_sys  = avs_write_in && avs_address_in == OFS_SYSCLK  && clk_en_in;
    assign wr_osc  = avs_write_in && avs_address_in == OFS_OSCCTL  && clk_en_in;
    assign wr_stby = avs_write_in && avs_address_in == OFS_STBYCTL && clk_en_in;
    assign wr_stat = avs_write_in && avs_address_in == OFS_STATUS  && clk_en_in;
    assign rd_go   = avs_read_in && !rd_pend_r;

    localparam logic [WU_W+3:0] CTR_ONE = {{(WU_W+3){1'b0}}, 1'b1};

    always_comb begin
        gear_nxt     = gear_r;
        gear_req_nxt = gear_req_r;
        gear_dly_nxt = gear_dly_r;
        prsc_nxt     = prsc_r;
        psrc_nxt     = psrc_r;
        pll_on_nxt   = pll_on_r;
        sela_nxt     = sela_r;
        selb_nxt     = selb_r;
        wucnt_nxt    = wucnt_r;
        busy_nxt     = busy_r;
        wu_ctr_nxt   = wu_ctr_r;
        stby_nxt     = stby_r;
        drive_nxt    = drive_r;
        stop_wake_en_nxt = stop_wake_en_r;
        mode_nxt     = mode_r;
        rd_pend_nxt  = rd_go;
        // count ticks to value times sixteen; reloads below win
        if (busy_r && osc_tick_in) begin
            if (wu_ctr_r + CTR_ONE >= ({4'h0, wucnt_r} << WU_SHIFT)) begin
                busy_nxt = 1'b0;
            end else begin
                wu_ctr_nxt = wu_ctr_r + CTR_ONE;
            end
        end
        if (wr_sys && avs_byteenable_in[0]) begin
            gear_req_nxt = avs_writedata_in[GEAR_LSB +: 3];
            gear_dly_nxt = 3'(GEAR_DELAY);
        end else if (gear_dly_r != 3'h0) begin
            gear_dly_nxt = gear_dly_r - 3'h1;
            if (gear_dly_r == 3'h1) begin
                gear_nxt = gear_req_r;
            end
        end
        if (wr_sys && avs_byteenable_in[0]) begin
            prsc_nxt = avs_writedata_in[PRSC_LSB +: 3];
        end
        if (wr_sys && avs_byteenable_in[1]) begin
            psrc_nxt = avs_writedata_in[PSRC_BIT];
        end
        if (wr_osc && avs_byteenable_in[0]) begin
            pll_on_nxt = avs_writedata_in[PLL_ON_BIT];
            if (avs_writedata_in[WU_START_BIT]) begin
                busy_nxt   = 1'b1;
                wu_ctr_nxt = '0;
            end
        end
        if (wr_osc && avs_byteenable_in[1]) begin
            sela_nxt = avs_writedata_in[WU_SELA_BIT];
            selb_nxt = avs_writedata_in[WU_SELB_BIT];
        end
        if (wr_osc && avs_byteenable_in[2] && avs_byteenable_in[3]) begin
            wucnt_nxt = avs_writedata_in[WU_CNT_LSB +: WU_W];
        end
        if (wr_stby && avs_byteenable_in[0]) begin
            stby_nxt = avs_writedata_in[STBY_LSB +: 3];
        end
        if (wr_stby && avs_byteenable_in[2]) begin
            drive_nxt = avs_writedata_in[DRIVE_BIT];
        end
        if (wr_stat && avs_byteenable_in[0]) begin
            stop_wake_en_nxt = avs_writedata_in[0];
        end
        unique case (mode_r)
            CGSWU_NORMAL: begin
                // entry on wait-for-interrupt with select set
                // only the two encodings enter a mode
                if (wfi_in && stby_r == STBY_IDLE) begin
                    mode_nxt = CGSWU_IDLE;
                end else if (wfi_in && stby_r == STBY_STOP) begin
                    mode_nxt = CGSWU_STOP;
                end
            end
            CGSWU_IDLE: begin
                // interrupt or watchdog NMI wakes IDLE
                if (irq_wake_in || watchdog_nmi_request_in) begin
                    mode_nxt = CGSWU_NORMAL;
                end
            end
            CGSWU_STOP: begin
                if (irq_wake_in && stop_wake_en_r) begin
                    mode_nxt   = CGSWU_WARM;
                    busy_nxt   = 1'b1;
                    wu_ctr_nxt = '0;
                end
            end
            CGSWU_WARM: begin
                if (!busy_r) begin
                    mode_nxt = CGSWU_NORMAL;
                end
            end
        endcase
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (avs_address_in)
            OFS_SYSCLK: begin
                rdata_nxt[GEAR_LSB +: 3] = gear_r;
                rdata_nxt[PRSC_LSB +: 3] = prsc_r;
                rdata_nxt[PSRC_BIT]      = psrc_r;
            end
            OFS_OSCCTL: begin
                rdata_nxt[WU_BUSY_BIT]          = busy_r;
                rdata_nxt[PLL_ON_BIT]           = pll_on_r;
                rdata_nxt[WU_SELA_BIT]          = sela_r;
                rdata_nxt[WU_SELB_BIT]          = selb_r;
                rdata_nxt[WU_CNT_LSB +: WU_W]   = wucnt_r;
            end
            OFS_STBYCTL: begin
                rdata_nxt[STBY_LSB +: 3] = stby_r;
                rdata_nxt[DRIVE_BIT]     = drive_r;
            end
            OFS_STATUS: begin
                rdata_nxt[0]   = stop_wake_en_r;
                rdata_nxt[5:4] = mode_r;
            end
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // =====================================================
    // State registers
    // reset gives NORMAL with no warm-up
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_r         <= CGSWU_NORMAL;
            gear_r         <= GEAR_RST;
            gear_req_r     <= GEAR_RST;
            gear_dly_r     <= 3'h0;
            prsc_r         <= PRSC_RST;
            psrc_r         <= 1'b0;
            pll_on_r       <= 1'b0;
            sela_r         <= 1'b0;
            selb_r         <= 1'b0;
            wucnt_r        <= WUCNT_RST;
            busy_r         <= 1'b0;
            wu_ctr_r       <= '0;
            stby_r         <= STBY_RST;
            drive_r        <= 1'b0;
            stop_wake_en_r <= 1'b0;
            rd_pend_r      <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else if (clk_en_in) begin
            mode_r         <= mode_nxt;
            gear_r         <= gear_nxt;
            gear_req_r     <= gear_req_nxt;
            gear_dly_r     <= gear_dly_nxt;
            prsc_r         <= prsc_nxt;
            psrc_r         <= psrc_nxt;
            pll_on_r       <= pll_on_nxt;
            sela_r         <= sela_nxt;
            selb_r         <= selb_nxt;
            wucnt_r        <= wucnt_nxt;
            busy_r         <= busy_nxt;
            wu_ctr_r       <= wu_ctr_nxt;
            stby_r         <= stby_nxt;
            drive_r        <= drive_nxt;
            stop_wake_en_r <= stop_wake_en_nxt;
            rd_pend_r      <= rd_pend_nxt;
            if (rd_go) begin
                avs_readdata_out <= rdata_nxt;
            end
        end
    end

    // =====================================================
    // Outputs from registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gear_div_out          <= 5'h01;
            prescale_div_out      <= 5'h01;
            periph_source_sel_out <= 1'b0;
            pll_x8_en_out         <= 1'b0;
            mode_out              <= CGSWU_NORMAL;
        end else if (clk_en_in) begin
            gear_div_out          <= div_of(gear_nxt);
            prescale_div_out      <= div_of(prsc_nxt);
            periph_source_sel_out <= psrc_nxt;
            pll_x8_en_out         <= pll_on_nxt && mode_nxt == CGSWU_NORMAL;
            mode_out              <= mode_nxt;
        end
    end

    assign core_clk_en_out         = mode_r == CGSWU_NORMAL;
    assign idle_periph_clk_en_out  = mode_r == CGSWU_NORMAL ? 4'hF :
                                     mode_r == CGSWU_IDLE ? idle_run_en_in : 4'h0;
    assign fixed_periph_clk_en_out = mode_r == CGSWU_NORMAL || mode_r == CGSWU_IDLE;
    assign analog_clk_en_out       = 1'b1;
    // oscillator halts in STOP; runs during warm-up
    assign osc_run_out             = mode_r != CGSWU_STOP;
    assign pin_io_en_out    = (mode_r != CGSWU_STOP) || drive_r;
    assign osc_pin_high_out = mode_r == CGSWU_STOP;

    // =====================================================
    // Checks
    a_gear_delay: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (wr_sys && avs_byteenable_in[0]) ##1 (clk_en_in && !wr_sys)[*5] |=> gear_r == gear_req_r)
        else $error("gear not applied after delay");
    a_gear_reset: assert property (@(posedge clock_in) $rose(rst_n_in) |-> gear_r == 3'h0)
        else $error("gear not 1/1 after reset");
    a_idle_entry: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in && mode_r == CGSWU_NORMAL && wfi_in && stby_r == STBY_IDLE
        |=> mode_r == CGSWU_IDLE) else $error("idle not entered");
    a_stop_nmi: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        mode_r == CGSWU_STOP && !irq_wake_in |=> mode_r == CGSWU_STOP)
        else $error("nmi woke stop");
    a_idle_wake: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in && mode_r == CGSWU_IDLE && watchdog_nmi_request_in
        |=> mode_r == CGSWU_NORMAL) else $error("idle wake missed");
    a_warm_core: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        mode_r == CGSWU_WARM |-> !core_clk_en_out && busy_r || mode_nxt == CGSWU_NORMAL)
        else $error("core clocked during warm-up");
    a_stop_pins: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        mode_r == CGSWU_STOP |-> pin_io_en_out == drive_r && osc_pin_high_out)
        else $error("stop pin state wrong");
    a_idle_gate: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        mode_r == CGSWU_IDLE |-> !core_clk_en_out && idle_periph_clk_en_out == idle_run_en_in)
        else $error("idle gating wrong");
    a_busy_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        busy_r && wucnt_r == '0 && osc_tick_in && clk_en_in && !wr_osc |=> !busy_r)
        else $error("busy not cleared");
    c_idle_cycle: cover property (@(posedge clock_in) mode_r == CGSWU_IDLE ##1
        mode_r == CGSWU_NORMAL);
    c_stop_warm: cover property (@(posedge clock_in) mode_r == CGSWU_WARM ##1
        mode_r == CGSWU_NORMAL);
    c_gear_set: cover property (@(posedge clock_in) gear_r == 3'h4);
endmodule : cgswu_top
`default_nettype wire

// >>> include/cgswu_pkg.sv
// Package of constants for the clock gear, standby and warm-up controller
`default_nettype none
package cgswu_pkg;
    // Register word offsets (byte addresses)
    localparam logic [3:0] OFS_SYSCLK  = 4'h0;
    localparam logic [3:0] OFS_OSCCTL  = 4'h4;
    localparam logic [3:0] OFS_STBYCTL = 4'h8;
    localparam logic [3:0] OFS_STATUS  = 4'hC;
    // System clock register fields
    localparam int GEAR_LSB    = 0;
    localparam int PRSC_LSB    = 4;
    localparam int PSRC_BIT    = 8;
    // Oscillator control register fields
    localparam int WU_START_BIT = 0;
    localparam int WU_BUSY_BIT  = 1;
    localparam int PLL_ON_BIT   = 2;
    localparam int WU_SELA_BIT  = 8;
    localparam int WU_SELB_BIT  = 9;
    localparam int WU_CNT_LSB   = 20;
    // Standby control register fields
    localparam int STBY_LSB     = 0;
    localparam int DRIVE_BIT    = 16;
    // Reset values
    localparam logic [2:0]  GEAR_RST  = 3'h0;
    localparam logic [2:0]  PRSC_RST  = 3'h0;
    localparam logic [2:0]  STBY_RST  = 3'h0;
    localparam logic [11:0] WUCNT_RST = 12'h000;
    // Standby select encodings
    localparam logic [2:0]  STBY_STOP = 3'h1;
    localparam logic [2:0]  STBY_IDLE = 3'h3;
    // Warm-up count scale: value holds count with four low bits dropped
    localparam int WU_SHIFT   = 4;
    // Gear switch delay in clock cycles
    localparam int GEAR_DELAY = 4;
    localparam int PLL_MULT   = 8;
    typedef enum logic [1:0] {
        CGSWU_NORMAL = 2'b00,
        CGSWU_IDLE   = 2'b01,
        CGSWU_STOP   = 2'b10,
        CGSWU_WARM   = 2'b11
    } cgswu_mode_t;
endpackage : cgswu_pkg
`default_nettype wire

// >>> sim/cgswu_core_model.sv
// Behavioural core, wake source and oscillator facing the controller
`default_nettype none
module cgswu_core_model #(
    parameter int TICK_GAP = 3
) (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic core_clk_en_in,
    input  wire logic osc_run_in,
    input  wire logic sleep_cmd_in,
    input  wire logic wake_cmd_in,
    output logic      wfi_out,
    output logic      irq_wake_out,
    output logic      osc_tick_out
);
    timeunit 1ns;
    timeprecision 1ns;

    int unsigned gap_r;

    // ==========================================================
    // Core side
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wfi_out      <= 1'b0;
            irq_wake_out <= 1'b0;
        end else begin
            wfi_out <= sleep_cmd_in & core_clk_en_in;
            if (wake_cmd_in) begin
                irq_wake_out <= 1'b1;
            end else if (core_clk_en_in) begin
                irq_wake_out <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Oscillator: slow ticks, silent while halted
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap_r        <= 0;
            osc_tick_out <= 1'b0;
        end else if (!osc_run_in) begin
            gap_r        <= 0;
            osc_tick_out <= 1'b0;
        end else begin
            osc_tick_out <= (gap_r == 0);
            gap_r        <= (gap_r == TICK_GAP - 1) ? 0 : gap_r + 1;
        end
    end
endmodule // cgswu_core_model
`default_nettype wire

// >>> sim/clock_gear_standby_warmup_tb.sv
// Self-checking bench for the clock gear, standby and warm-up controller
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module clock_gear_standby_warmup_tb
    import cgswu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock_in, rst_n_in, clk_en, rd_en, wr_en, sleep_cmd, wake_cmd, nmi;
    logic [3:0]  addr, idle_en, idle_clk, be;
    logic [31:0] wdata, rdata, rd;
    logic        waitreq, wfi_w, irq_w, tick_w, core_en, fixed_en, ana_en, osc_run;
    logic        pin_en, osc_high, psrc, pll_en;
    logic [4:0]  gear_div, prsc_div;
    logic [1:0]  mode;
    logic [2:0]  code, pc;
    int          err_total, checks_done, warm_ticks, warm_cyc, cnt, n;

    cgswu_top uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
        .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .wfi_in(wfi_w), .irq_wake_in(irq_w),
        .watchdog_nmi_request_in(nmi), .idle_run_en_in(idle_en), .osc_tick_in(tick_w),
        .gear_div_out(gear_div), .prescale_div_out(prsc_div), .periph_source_sel_out(psrc),
        .pll_x8_en_out(pll_en), .core_clk_en_out(core_en), .idle_periph_clk_en_out(idle_clk),
        .fixed_periph_clk_en_out(fixed_en), .analog_clk_en_out(ana_en),
        .osc_run_out(osc_run), .pin_io_en_out(pin_en), .osc_pin_high_out(osc_high),
        .mode_out(mode));

    cgswu_core_model #(.TICK_GAP(3)) core_model (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .core_clk_en_in(core_en), .osc_run_in(osc_run), .sleep_cmd_in(sleep_cmd),
        .wake_cmd_in(wake_cmd), .wfi_out(wfi_w), .irq_wake_out(irq_w), .osc_tick_out(tick_w));

    // ==========================================================
    // Clock and warm-up observation
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        if (mode === CGSWU_IDLE || mode === CGSWU_STOP) begin
            warm_ticks <= 0;
            warm_cyc   <= 0;
        end else if (mode === CGSWU_WARM) begin
            warm_cyc   <= warm_cyc + 1;
            warm_ticks <= warm_ticks + int'(tick_w === 1'b1);
        end
    end

    // ==========================================================
    // Bus and helper tasks
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        do @(posedge clock_in); while (waitreq !== 1'b0);
        wr_en <= 1'b0;
        @(posedge clock_in);
    endtask

    // Read data stands at the edge where waitrequest is seen low
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        addr  <= a;
        rd_en <= 1'b1;
        do @(posedge clock_in); while (waitreq !== 1'b0);
        d = rdata;
        rd_en <= 1'b0;
        @(posedge clock_in);
    endtask

    task automatic wait_mode(input logic [1:0] m);
        int k;
        k = 0;
        while (mode !== m && k < 3000) begin
            @(posedge clock_in);
            k++;
        end
        `CHK("mode", m, mode)
    endtask

    task automatic go_sleep(input logic [2:0] sel, input logic keep);
        bus_wr(OFS_STBYCTL, {15'h0, keep, 13'h0, sel});
        sleep_cmd <= 1'b1;
        @(posedge clock_in);
        sleep_cmd <= 1'b0;
        wait_mode((sel == STBY_STOP) ? CGSWU_STOP : CGSWU_IDLE);
    endtask

    task automatic check_reset();
        for (int a = 0; a < 16; a += 4) begin
            bus_rd(4'(a), rd);
            `CHK("reg rst", 32'h0, rd)
        end
        `CHK("gear rst", 5'h01, gear_div)
        `CHK("prsc rst", 5'h01, prsc_div)
        `CHK("core rst", 1'b1, core_en)
        `CHK("pins rst", 1'b1, pin_en)
        `CHK("pll rst", 1'b0, pll_en)
    endtask

    function automatic logic [4:0] exp_div(input logic [2:0] c);
        return (c <= 3'h4) ? 5'(5'h01 << c) : 5'h01;
    endfunction

    task automatic test_done();
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rst_n_in, rd_en, wr_en, sleep_cmd, wake_cmd, nmi} = '0;
        clk_en = 1'b1;
        addr = '0;
        wdata = '0;
        idle_en = '0;
        be = 4'hF;
        void'($urandom(46));
        // reset held long enough for a stable oscillator
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        check_reset();
        bus_wr(4'h2, 32'hFFFF_FFFF);
        bus_rd(4'h2, rd);
        `CHK("unmapped", 32'h0, rd)
        // Count lanes off: the count field must keep its value
        be <= 4'h3;
        bus_wr(OFS_OSCCTL, 32'hFFF0_0000);
        be <= 4'hF;
        bus_rd(OFS_OSCCTL, rd);
        `CHK("lane count", 12'h000, rd[31:20])
        for (int i = 0; i < 7; i++) begin
            code = (i < 5) ? 3'(i) : 3'($urandom_range(0, 7));
            pc = 3'($urandom_range(0, 4));
            n = gear_div;
            bus_wr(OFS_SYSCLK, {23'h0, 1'(i), 1'b0, pc, 1'b0, code});
            `CHK("gear early", 5'(n), gear_div)
            repeat (8) @(posedge clock_in);
            `CHK("gear", exp_div(code), gear_div)
            `CHK("prsc", exp_div(pc), prsc_div)
            `CHK("psrc", 1'(i), psrc)
        end
        clk_en <= 1'b0;
        bus_wr(OFS_SYSCLK, 32'h0);
        repeat (8) @(posedge clock_in);
        `CHK("frozen", exp_div(code), gear_div)
        clk_en <= 1'b1;
        idle_en <= 4'($urandom);
        go_sleep(STBY_IDLE, 1'b0);
        `CHK("core idle", 1'b0, core_en)
        `CHK("idle run", idle_en, idle_clk)
        `CHK("fixed idle", 1'b1, fixed_en)
        `CHK("osc idle", 1'b1, osc_run)
        nmi <= 1'b1;
        wait_mode(CGSWU_NORMAL);
        nmi <= 1'b0;
        `CHK("idle warm", 0, warm_cyc)
        for (int k = 0; k < 2; k++) begin
            cnt = $urandom_range(1, 3);
            // count set, select A zero, no start
            bus_wr(OFS_OSCCTL, {12'(cnt), 10'h0, 1'(k), 1'b0, 5'h0, 3'h4});
            bus_wr(OFS_STATUS, 32'h1);
            go_sleep(STBY_STOP, 1'(k));
            `CHK("pins stop", 1'(k), pin_en)
            `CHK("x2 high", 1'b1, osc_high)
            `CHK("osc stop", 1'b0, osc_run)
            `CHK("fixed stop", 1'b0, fixed_en)
            `CHK("idle stop", 4'h0, idle_clk)
            `CHK("analog", 1'b1, ana_en)
            nmi <= 1'b1;
            repeat (10) @(posedge clock_in);
            nmi <= 1'b0;
            `CHK("nmi stop", CGSWU_STOP, mode)
            wake_cmd <= 1'b1;
            @(posedge clock_in);
            wake_cmd <= 1'b0;
            wait_mode(CGSWU_WARM);
            bus_rd(OFS_OSCCTL, rd);
            `CHK("busy warm", 1'b1, rd[1])
            `CHK("core warm", 1'b0, core_en)
            wait_mode(CGSWU_NORMAL);
            `CHK("warm len", 1'b1, warm_ticks >= 16 * cnt && warm_ticks <= 16 * cnt + 1)
            bus_rd(OFS_OSCCTL, rd);
            `CHK("busy done", 1'b0, rd[1])
            `CHK("pll kept", 1'b1, pll_en)
        end
        bus_wr(OFS_OSCCTL, {12'h001, 17'h0, 3'h1});
        bus_rd(OFS_OSCCTL, rd);
        `CHK("busy sw", 1'b1, rd[1])
        n = 0;
        while (rd[1] !== 1'b0 && n < 200) begin
            bus_rd(OFS_OSCCTL, rd);
            n++;
        end
        `CHK("busy sw done", 1'b0, rd[1])
        go_sleep(STBY_STOP, 1'b1);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        `CHK("mode rst", CGSWU_NORMAL, mode)
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        `CHK("no warm", 0, warm_cyc)
        check_reset();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        err_total++;
        test_done();
    end
endmodule // clock_gear_standby_warmup_tb
`undef CHK
`default_nettype wire
